/* sgps_top.sv */
// Switchgear position supervisor: contact decode, travel and settle
// timing, interlocks, drive outputs and a classic Wishbone slave.
// Assumes contacts and commands are synchronous to clk_i.
//
// Functional notes
// - Open command runs open timer, shows transit.
// - Position before expiry valid, else fault.
// - Two contacts decode to codes 0..3.
// - Single contact wiring raises single contact flag.
// - Single contact supervises one direction only.
// - Closed-only: close success gives closed, success pulse.
// - Closed-only: expiry gives fault, drops transit.
// - Closed-only: settle timer after travel, then closed.
// - Closed-only contact decode 2, 0, 1.
// - Unassigned single contact forces code 3.
// - Open-only: open success gives open, success pulse.
// - Open-only: expiry gives fault, drops transit.
// - Open-only: settle timer after travel, then open.
// - Open-only contact decode 1, 0, 2.
// - Three interlocks per direction block commands.
// - Protection open and reclose bypass interlocks.
// - Close command runs close timer, valid or fault.
// - Drive held at most travel time, ends early.
//
// Added by the designer: the placing of the registers and the Wishbone register port.
module sgps_top #(
    parameter int MOVE_OPEN_DEF = sgps_pkg::MOVE_CYCLES,
    parameter int MOVE_CLOSE_DEF = sgps_pkg::MOVE_CYCLES,
    parameter int NIL = sgps_pkg::NUM_INTERLOCKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [sgps_pkg::ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Auxiliary contacts.
    input wire logic aux_closed_i,
    input wire logic aux_open_i,
    // Command sources.
    input wire logic cmd_open_i,
    input wire logic cmd_close_i,
    input wire logic prot_open_i,
    input wire logic auto_reclose_i,
    input wire logic [NIL-1:0] ilock_open_i,
    input wire logic [NIL-1:0] ilock_close_i,
    // Drive relays and status.
    output logic drive_open_o,
    output logic drive_close_o,
    output logic pos_closed_o,
    output logic pos_open_o,
    output logic pos_transit_o,
    output logic pos_fault_o,
    output logic [1:0] pos_code_o,
    output logic single_contact_flag_o,
    output logic command_success_o,
    output logic cmd_blocked_o
);
    localparam int TW = sgps_pkg::TIMER_W;

    logic [31:0] cfg;
    logic [TW-1:0] move_open;
    logic [TW-1:0] move_close;
    logic [1:0] wiring;
    logic no_input;
    logic [TW-1:0] settle_load;
    logic [31:0] wr_mask;
    logic wb_req;

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    // Ack comes one cycle after the request and drops the next cycle.
    assign wb_req = cyc_i && stb_i && !ack_o;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wr_mask[b*8 +: 8] = {8{sel_i[b]}};
        end
    end

    // Ack generation; unmapped addresses are acked and read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else if (ce_i) begin
            ack_o <= wb_req;
        end
    end

    // Register writes take effect when ack is given.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg <= sgps_pkg::CFG_RESET;
            move_open <= TW'(MOVE_OPEN_DEF);
            move_close <= TW'(MOVE_CLOSE_DEF);
        end else if (ce_i && wb_req && we_i) begin
            unique case (adr_i)
                sgps_pkg::REG_CONFIG: cfg <= (cfg & ~wr_mask) | (dat_i & wr_mask);
                sgps_pkg::REG_MOVE_OPEN: begin
                    move_open <= (move_open & ~wr_mask) | (dat_i & wr_mask);
                end
                sgps_pkg::REG_MOVE_CLOSE: begin
                    move_close <= (move_close & ~wr_mask) | (dat_i & wr_mask);
                end
                default: ;
            endcase
        end
    end

    // Read data is registered alongside ack.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (ce_i && wb_req && !we_i) begin
            unique case (adr_i)
                sgps_pkg::REG_CONFIG: dat_o <= cfg;
                sgps_pkg::REG_STATUS: begin
                    dat_o <= {21'h00000, cmd_blocked_o, command_success_o,
                              drive_close_o, drive_open_o, single_contact_flag_o,
                              pos_fault_o, pos_transit_o, pos_open_o,
                              pos_closed_o, pos_code_o};
                end
                sgps_pkg::REG_MOVE_OPEN: dat_o <= move_open;
                sgps_pkg::REG_MOVE_CLOSE: dat_o <= move_close;
                default: dat_o <= '0;
            endcase
        end
    end

    assign wiring = cfg[sgps_pkg::CFG_WIRE_LSB +: 2];
    assign no_input = cfg[sgps_pkg::CFG_NOINPUT_BIT];
    assign settle_load = TW'(cfg[sgps_pkg::CFG_SETTLE_LSB +: sgps_pkg::CFG_SETTLE_W]);

    // ****************************************************************
    // Command qualification
    // ****************************************************************
    logic blk_open;
    logic blk_close;
    logic go_open;
    logic go_close;
    logic busy;

    // Any active interlock blocks its direction.
    assign blk_open = |ilock_open_i;
    assign blk_close = |ilock_close_i;

    // Protection and reclose bypass interlocks; open has priority.
    assign go_open = !busy && ((cmd_open_i && !blk_open) || prot_open_i);
    assign go_close = !busy && !go_open &&
                      ((cmd_close_i && !blk_close) || auto_reclose_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_blocked_o <= 1'b0;
        end else if (ce_i) begin
            cmd_blocked_o <= (cmd_open_i && blk_open && !prot_open_i) ||
                             (cmd_close_i && blk_close && !auto_reclose_i);
        end
    end

    // ****************************************************************
    // Supervision sequencer
    // ****************************************************************
    typedef enum logic [1:0] {
        SGPS_IDLE,
        SGPS_MOVE,
        SGPS_SETTLE
    } sgps_state_t;

    sgps_state_t state;
    logic dir_close;
    logic fault_latch;
    logic reached;
    logic mv_start;
    logic mv_run;
    logic mv_exp;
    logic st_start;
    logic st_run;
    logic st_exp;
    logic supervised;
    logic settle_end;
    logic hold_target;

    assign busy = (state != SGPS_IDLE);
    assign mv_start = go_open || go_close;

    // Target position read from the contacts that are wired.
    always_comb begin
        unique case (wiring)
            sgps_pkg::WIRE_CLOSED_ONLY: reached = dir_close ? aux_closed_i : !aux_closed_i;
            sgps_pkg::WIRE_OPEN_ONLY: reached = dir_close ? !aux_open_i : aux_open_i;
            default: reached = dir_close ? (aux_closed_i && !aux_open_i)
                                         : (!aux_closed_i && aux_open_i);
        endcase
    end

    // Single contact only supervises its own direction.
    assign supervised = (wiring == sgps_pkg::WIRE_BOTH) ||
                        (wiring == sgps_pkg::WIRE_CLOSED_ONLY && dir_close) ||
                        (wiring == sgps_pkg::WIRE_OPEN_ONLY && !dir_close);

    sgps_timer #(.WIDTH(TW)) u_move (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(mv_start),
        .stop_i(state == SGPS_MOVE && reached),
        .load_i(go_close ? move_close : move_open),
        .run_o(mv_run),
        .expire_o(mv_exp)
    );

    // Settle starts when travel time ends, if a settle time is set.
    assign st_start = mv_exp && (settle_load != '0);

    sgps_timer #(.WIDTH(TW)) u_settle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(st_start),
        .stop_i(1'b0),
        .load_i(settle_load),
        .run_o(st_run),
        .expire_o(st_exp)
    );

    assign settle_end = (state == SGPS_SETTLE) && !st_run && !st_start;

    // Sequencer; reset leaves no timer running.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= SGPS_IDLE;
            dir_close <= 1'b0;
            fault_latch <= 1'b0;
            hold_target <= 1'b0;
            command_success_o <= 1'b0;
        end else if (ce_i) begin
            command_success_o <= 1'b0;
            unique case (state)
                SGPS_IDLE: begin
                    if (mv_start) begin
                        state <= SGPS_MOVE;
                        dir_close <= go_close;
                        fault_latch <= 1'b0;
                        hold_target <= 1'b0;
                    end
                end
                SGPS_MOVE: begin
                    if (reached && mv_run) begin
                        // Success before expiry.
                        state <= SGPS_IDLE;
                        command_success_o <= 1'b1;
                    end else if (mv_exp) begin
                        // Expiry: fault if supervised and not reached, then settle if a settle time is set.
                        fault_latch <= supervised && !reached;
                        state <= st_start ? SGPS_SETTLE : SGPS_IDLE;
                    end
                end
                SGPS_SETTLE: begin
                    if (st_exp || settle_end) begin
                        state <= SGPS_IDLE;
                        fault_latch <= 1'b0;
                        // One contact cannot confirm, so the target is taken as reached.
                        hold_target <= (wiring != sgps_pkg::WIRE_BOTH);
                    end
                end
                default: state <= SGPS_IDLE;
            endcase
        end
    end

    // Drive held while travel timer runs, cut at arrival.
    assign drive_open_o = (state == SGPS_MOVE) && !dir_close && mv_run && !reached;
    assign drive_close_o = (state == SGPS_MOVE) && dir_close && mv_run && !reached;

    // ****************************************************************
    // Position decode
    // ****************************************************************
    logic timing;
    logic [1:0] code;

    // Transit shows while a supervised travel or a settle runs.
    assign timing = ((state == SGPS_MOVE) && mv_run && supervised) ||
                    (state == SGPS_SETTLE);

    always_comb begin
        code = sgps_pkg::POS_FAULT;
        if (wiring != sgps_pkg::WIRE_BOTH && no_input) begin
            code = sgps_pkg::POS_FAULT;
        end else if (state == SGPS_SETTLE) begin
            code = sgps_pkg::POS_TRANSIT;
        end else if (fault_latch || (state == SGPS_MOVE && mv_exp && supervised && !reached)) begin
            // The expiry cycle itself already shows fault, not a stale contact.
            code = sgps_pkg::POS_FAULT;
        end else if (hold_target) begin
            code = dir_close ? sgps_pkg::POS_CLOSED : sgps_pkg::POS_OPEN;
        end else begin
            unique case (wiring)
                sgps_pkg::WIRE_CLOSED_ONLY: begin
                    if (aux_closed_i) code = sgps_pkg::POS_CLOSED;
                    else if (timing) code = sgps_pkg::POS_TRANSIT;
                    else code = sgps_pkg::POS_OPEN;
                end
                sgps_pkg::WIRE_OPEN_ONLY: begin
                    if (aux_open_i) code = sgps_pkg::POS_OPEN;
                    else if (timing) code = sgps_pkg::POS_TRANSIT;
                    else code = sgps_pkg::POS_CLOSED;
                end
                default: begin
                    if (aux_closed_i && !aux_open_i) code = sgps_pkg::POS_CLOSED;
                    else if (!aux_closed_i && aux_open_i) code = sgps_pkg::POS_OPEN;
                    else if (timing) code = sgps_pkg::POS_TRANSIT;
                    else code = sgps_pkg::POS_FAULT;
                end
            endcase
        end
    end

    // Indications are registered from one code, so exactly one is set.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_code_o <= sgps_pkg::POS_FAULT;
            pos_closed_o <= 1'b0;
            pos_open_o <= 1'b0;
            pos_transit_o <= 1'b0;
            pos_fault_o <= 1'b1;
            single_contact_flag_o <= 1'b0;
        end else if (ce_i) begin
            pos_code_o <= code;
            pos_closed_o <= (code == sgps_pkg::POS_CLOSED);
            pos_open_o <= (code == sgps_pkg::POS_OPEN);
            pos_transit_o <= (code == sgps_pkg::POS_TRANSIT);
            pos_fault_o <= (code == sgps_pkg::POS_FAULT);
            single_contact_flag_o <= (wiring != sgps_pkg::WIRE_BOTH);
        end
    end
endmodule

/* sgps_pkg.sv */
// Package for the switchgear position supervisor.
// Assumes a 100 MHz system clock; all timer counts derive from it.
package sgps_pkg;
    // ****************************************************************
    // Position codes
    // ****************************************************************
    localparam logic [1:0] POS_TRANSIT = 2'h0;
    localparam logic [1:0] POS_OPEN = 2'h1;
    localparam logic [1:0] POS_CLOSED = 2'h2;
    localparam logic [1:0] POS_FAULT = 2'h3;

    // ****************************************************************
    // Wiring modes
    // ****************************************************************
    localparam logic [1:0] WIRE_BOTH = 2'h0;
    localparam logic [1:0] WIRE_CLOSED_ONLY = 2'h1;
    localparam logic [1:0] WIRE_OPEN_ONLY = 2'h2;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 100;
    localparam int MOVE_TIME_MS = 100;
    localparam int SETTLE_TIME_MS = 0;
    localparam int MOVE_CYCLES = MOVE_TIME_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_CYCLES = SETTLE_TIME_MS * 1000 * CLK_MHZ;
    localparam int TIMER_W = 32;
    localparam int NUM_INTERLOCKS = 3;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_MOVE_OPEN = 4'h8;
    localparam logic [3:0] REG_MOVE_CLOSE = 4'hC;
    localparam int ADDR_W = 4;
    // Config field positions.
    localparam int CFG_WIRE_LSB = 0;
    localparam int CFG_NOINPUT_BIT = 2;
    localparam int CFG_SETTLE_LSB = 8;
    localparam int CFG_SETTLE_W = 24;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
endpackage

/* sgps_timer.sv */
// Down-counting one-shot timer for travel and settle supervision.
// Assumes a synchronous reset and a shared clock enable.
module sgps_timer #(
    parameter int WIDTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [WIDTH-1:0] load_i,
    output logic run_o,
    output logic expire_o
);
    logic [WIDTH-1:0] count;

    // ****************************************************************
    // Counter
    // ****************************************************************
    // A load of zero never runs, so an unset settle time is skipped.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
            expire_o <= 1'b0;
        end else if (ce_i) begin
            expire_o <= 1'b0;
            if (stop_i) begin
                count <= '0;
            end else if (start_i) begin
                count <= load_i;
            end else if (count != '0) begin
                count <= count - 1'b1;
                if (count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    expire_o <= 1'b1;
                end
            end
        end
    end

    assign run_o = (count != '0);
endmodule

/* sgps_gear_model.sv */
// Behavioural switchgear mechanism driving the auxiliary contacts.
// Assumes the supervisor's drive outputs and one shared clock.
module sgps_gear_model #(
    parameter int DELAY = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic drive_open_i,
    input wire logic drive_close_i,
    input wire logic stuck_i,
    output logic aux_closed_o,
    output logic aux_open_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic closed;
    logic [7:0] cnt;
    // Travel starts when driven towards the other end and, like a latched
    // mechanism, runs to its end even if the drive is cut; a jam stops it and clears the travel count.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            closed <= 1'b0;
            cnt <= 8'h00;
        end else if (!stuck_i && (cnt != 8'h00 || (closed ? drive_open_i : drive_close_i))) begin
            cnt <= (cnt == DELAY - 1) ? 8'h00 : cnt + 8'h01;
            if (cnt == DELAY - 1) begin
                closed <= !closed;
            end
        end else begin
            cnt <= 8'h00;
        end
    end
    // Both contacts read open in mid travel or when jammed, as real gear does.
    assign aux_closed_o = closed && cnt == 8'h00 && !stuck_i;
    assign aux_open_o = !closed && cnt == 8'h00 && !stuck_i;
endmodule

/* sgps_top_asserts.sv */
// Concurrent checks on the ports of the position supervisor.
// Assumes it is bound into sgps_top and that config writes leave move times alone.
module sgps_top_asserts #(
    parameter int MOVE_OPEN_DEF = 20,
    parameter int NIL = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ack_o,
    input wire logic aux_closed_i,
    input wire logic aux_open_i,
    input wire logic prot_open_i,
    input wire logic auto_reclose_i,
    input wire logic [NIL-1:0] ilock_open_i,
    input wire logic [NIL-1:0] ilock_close_i,
    input wire logic drive_open_o,
    input wire logic drive_close_o,
    input wire logic pos_closed_o,
    input wire logic pos_open_o,
    input wire logic pos_transit_o,
    input wire logic pos_fault_o,
    input wire logic [1:0] pos_code_o,
    input wire logic single_contact_flag_o,
    input wire logic command_success_o,
    input wire logic cmd_blocked_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] ocnt;
    // Length of the present open drive; a stuck timer would let it grow.
    always_ff @(posedge clk_i) begin
        if (rst_i || !drive_open_o) begin
            ocnt <= 32'h0;
        end else begin
            ocnt <= ocnt + 32'h1;
        end
    end
    // ****************************************************************
    // Indications
    // ****************************************************************
    onehot_ind_a: assert property ($onehot({pos_closed_o, pos_open_o, pos_transit_o, pos_fault_o}))
        else $error("indications not one-hot");
    code_match_a: assert property (pos_closed_o == (pos_code_o == sgps_pkg::POS_CLOSED)
        && pos_open_o == (pos_code_o == sgps_pkg::POS_OPEN)
        && pos_fault_o == (pos_code_o == sgps_pkg::POS_FAULT)) else $error("code mismatch");
    reset_state_a: assert property (disable iff (1'b0) rst_i |=> pos_fault_o
        && !drive_open_o && !drive_close_o && !ack_o) else $error("bad reset state");
    decode_both_a: assert property (!single_contact_flag_o && $past(!single_contact_flag_o)
        && $past(!rst_i) && !pos_fault_o && $past(!drive_open_o && !drive_close_o)
        && $past(aux_closed_i != aux_open_i)
        |-> pos_code_o == {$past(aux_closed_i), $past(aux_open_i)}) else $error("bad decode");
    success_pos_a: assert property (command_success_o |-> pos_closed_o || pos_open_o)
        else $error("success without end position");
    // ****************************************************************
    // Commands and drives
    // ****************************************************************
    // Transit can only show once both contacts have left their end position.
    open_transit_a: assert property ($rose(drive_open_o) && !single_contact_flag_o ##1
        (drive_open_o && aux_closed_i == aux_open_i) |=> pos_transit_o)
        else $error("no transit on open");
    close_transit_a: assert property ($rose(drive_close_o) && !single_contact_flag_o ##1
        (drive_close_o && aux_closed_i == aux_open_i) |=> pos_transit_o)
        else $error("no transit on close");
    drive_bound_a: assert property (ocnt <= 32'(MOVE_OPEN_DEF + 1))
        else $error("open drive too long");
    ilock_open_a: assert property ($rose(drive_open_o) |-> $past(prot_open_i)
        || $past(ilock_open_i) == '0) else $error("open drive despite interlock");
    ilock_close_a: assert property ($rose(drive_close_o) |-> $past(auto_reclose_i)
        || $past(ilock_close_i) == '0) else $error("close drive despite interlock");
    blocked_a: assert property (cmd_blocked_o |-> $past(|{ilock_open_i, ilock_close_i}))
        else $error("blocked without interlock");
    cover property (command_success_o);
    cover property ($rose(pos_fault_o));
    cover property (cmd_blocked_o);
endmodule
bind sgps_top sgps_top_asserts #(.MOVE_OPEN_DEF(MOVE_OPEN_DEF), .NIL(NIL)) u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ack_o(ack_o),
    .aux_closed_i(aux_closed_i),
    .aux_open_i(aux_open_i),
    .prot_open_i(prot_open_i),
    .auto_reclose_i(auto_reclose_i),
    .ilock_open_i(ilock_open_i),
    .ilock_close_i(ilock_close_i),
    .drive_open_o(drive_open_o),
    .drive_close_o(drive_close_o),
    .pos_closed_o(pos_closed_o),
    .pos_open_o(pos_open_o),
    .pos_transit_o(pos_transit_o),
    .pos_fault_o(pos_fault_o),
    .pos_code_o(pos_code_o),
    .single_contact_flag_o(single_contact_flag_o),
    .command_success_o(command_success_o),
    .cmd_blocked_o(cmd_blocked_o)
);

/* switchgear_position_supervisor_tb.sv */
// Self-checking bench for the switchgear position supervisor.
// Assumes the gear model on the contacts and move times of 20 cycles.
module switchgear_position_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, stuck;
    logic [3:0] adr_i, sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic aux_closed_i, aux_open_i, cmd_open_i, cmd_close_i, prot_open_i, auto_reclose_i;
    logic [2:0] ilock_open_i, ilock_close_i;
    logic drive_open_o, drive_close_o, pos_closed_o, pos_open_o, pos_transit_o, pos_fault_o;
    logic single_contact_flag_o, command_success_o, cmd_blocked_o;
    logic [1:0] pos_code_o;
    int n_mismatch = 0;
    int checked = 0;
    sgps_top #(.MOVE_OPEN_DEF(20), .MOVE_CLOSE_DEF(20)) u_dut (.clk_i, .rst_i, .ce_i,
        .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .aux_closed_i,
        .aux_open_i, .cmd_open_i, .cmd_close_i, .prot_open_i, .auto_reclose_i, .ilock_open_i,
        .ilock_close_i, .drive_open_o, .drive_close_o, .pos_closed_o, .pos_open_o,
        .pos_transit_o, .pos_fault_o, .pos_code_o, .single_contact_flag_o,
        .command_success_o, .cmd_blocked_o);
    sgps_gear_model u_gear (.clk_i, .rst_i, .drive_open_i(drive_open_o),
        .drive_close_i(drive_close_o), .stuck_i(stuck), .aux_closed_o(aux_closed_i),
        .aux_open_o(aux_open_i));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled, then release.
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {1'b1, 1'b1, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) n_mismatch++;
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    // One-cycle command; returns at the edge after the take edge.
    task automatic go(input logic [3:0] c);
        {auto_reclose_i, prot_open_i, cmd_close_i, cmd_open_i} <= c;
        @(posedge clk_i);
        {auto_reclose_i, prot_open_i, cmd_close_i, cmd_open_i} <= 4'h0;
        @(posedge clk_i);
    endtask
    task automatic wait_ok(input logic [1:0] exp);
        int n;
        n = 0;
        while (command_success_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 100) n_mismatch++;
        chk(pos_code_o, exp);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ****************************************************************
    // Clock, watchdog and tests
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = !clk_i;
    end
    // Whole run is well under a thousand cycles; this only cuts a hang.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        test_done();
    end
    initial begin
        {rst_i, ce_i, cyc_i, stb_i, we_i, stuck} = 6'h30;
        {adr_i, sel_i, dat_i} = {4'h0, 4'hF, 32'h0};
        {auto_reclose_i, prot_open_i, cmd_close_i, cmd_open_i} = 4'h0;
        {ilock_open_i, ilock_close_i} = 6'h00;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(pos_code_o, sgps_pkg::POS_OPEN);
        wb(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, sgps_pkg::REG_CONFIG, 32'h0);
        chk(q, sgps_pkg::CFG_RESET);
        go(4'h2);
        chk(drive_close_o, 1'b1);
        // The contacts break one edge after the drive, transit one edge later.
        repeat (2) @(posedge clk_i);
        chk(pos_transit_o, 1'b1);
        wait_ok(sgps_pkg::POS_CLOSED);
        chk(drive_close_o, 1'b0);
        for (int i = 0; i < 3; i++) begin
            ilock_open_i <= 3'(1 << i);
            go(4'h1);
            chk({cmd_blocked_o, drive_open_o}, 2'b10);
        end
        ilock_open_i <= 3'h7;
        go(4'h4);
        chk(drive_open_o, 1'b1);
        wait_ok(sgps_pkg::POS_OPEN);
        {ilock_open_i, stuck} <= {3'h0, 1'b1};
        go(4'h2);
        repeat (25) @(posedge clk_i);
        chk({pos_code_o, drive_close_o}, {sgps_pkg::POS_FAULT, 1'b0});
        {ilock_close_i, stuck} <= {3'h7, 1'b0};
        go(4'h8);
        chk(drive_close_o, 1'b1);
        wait_ok(sgps_pkg::POS_CLOSED);
        ilock_close_i <= 3'h0;
        wb(1'b1, sgps_pkg::REG_CONFIG, 32'h1);
        chk({single_contact_flag_o, pos_code_o}, {1'b1, sgps_pkg::POS_CLOSED});
        go(4'h1);
        repeat (25) @(posedge clk_i);
        chk(pos_code_o, sgps_pkg::POS_OPEN);
        stuck <= 1'b1;
        go(4'h2);
        @(posedge clk_i);
        chk(pos_code_o, sgps_pkg::POS_TRANSIT);
        repeat (25) @(posedge clk_i);
        chk({pos_code_o, pos_transit_o}, {sgps_pkg::POS_FAULT, 1'b0});
        // Settle of 5 cycles after a jammed travel, then the target is shown.
        wb(1'b1, sgps_pkg::REG_CONFIG, 32'h0000_0501);
        go(4'h2);
        repeat (24) @(posedge clk_i);
        chk(pos_code_o, sgps_pkg::POS_TRANSIT);
        repeat (10) @(posedge clk_i);
        chk(pos_code_o, sgps_pkg::POS_CLOSED);
        stuck <= 1'b0;
        go(4'h2);
        wait_ok(sgps_pkg::POS_CLOSED);
        wb(1'b1, sgps_pkg::REG_CONFIG, 32'h2);
        chk(pos_code_o, sgps_pkg::POS_CLOSED);
        go(4'h1);
        @(posedge clk_i);
        chk(pos_code_o, sgps_pkg::POS_TRANSIT);
        wait_ok(sgps_pkg::POS_OPEN);
        go(4'h2);
        repeat (25) @(posedge clk_i);
        chk(pos_code_o, sgps_pkg::POS_CLOSED);
        stuck <= 1'b1;
        go(4'h1);
        repeat (25) @(posedge clk_i);
        chk({pos_code_o, pos_transit_o}, {sgps_pkg::POS_FAULT, 1'b0});
        wb(1'b1, sgps_pkg::REG_CONFIG, 32'h0000_0502);
        go(4'h1);
        repeat (24) @(posedge clk_i);
        chk(pos_code_o, sgps_pkg::POS_TRANSIT);
        repeat (10) @(posedge clk_i);
        chk(pos_code_o, sgps_pkg::POS_OPEN);
        stuck <= 1'b0;
        wb(1'b1, sgps_pkg::REG_CONFIG, 32'h6);
        wb(1'b0, sgps_pkg::REG_STATUS, 32'h0);
        chk(q[6:0], 7'h63);
        test_done();
    end
endmodule
